// ### accel_offset_registers.sv
// Accelerometer offset register bank with offset-corrected sample outputs
// Summary of operation
// - High register of each axis holds offset bits 14 to 7.
// - Low register bits 7 to 1 hold offset bits 6 to 0; bit 0 reserved.
// - Offset is 15 bits, 0.98 mg step, +/-16 g, range independent.
// - Native Y at 122/123, Z at 125/126.
// - All offset registers readable, writable, reset to 0x00.
// - Legacy mode maps the six registers to addresses 6 through 11.
// - Native X at 119/120, read-write, reset zero.
`timescale 1ns/1ps
`default_nettype none

module accel_offset_registers (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic legacy_mode,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [47:0] raw_sample,
  output logic [47:0] corrected_sample
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] offset_high [accel_offset_pkg::AXES];
  logic [7:0] offset_low [accel_offset_pkg::AXES];
  logic [7:0] next_offset_high [accel_offset_pkg::AXES];
  logic [7:0] next_offset_low [accel_offset_pkg::AXES];
  logic [7:0] next_reg_rdata;
  logic next_reg_hit;
  logic [47:0] next_corrected_sample;
  logic [2:0] sel_high;
  logic [2:0] sel_low;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    if (legacy_mode)
    begin
      // Legacy map at 6..11
      sel_high = {reg_addr == accel_offset_pkg::LEGACY_Z_HIGH,
                  reg_addr == accel_offset_pkg::LEGACY_Y_HIGH,
                  reg_addr == accel_offset_pkg::LEGACY_X_HIGH};
      sel_low = {reg_addr == accel_offset_pkg::LEGACY_Z_LOW,
                 reg_addr == accel_offset_pkg::LEGACY_Y_LOW,
                 reg_addr == accel_offset_pkg::LEGACY_X_LOW};
    end
    else
    begin
      // Native map
      sel_high = {reg_addr == accel_offset_pkg::ADDR_Z_HIGH,
                  reg_addr == accel_offset_pkg::ADDR_Y_HIGH,
                  reg_addr == accel_offset_pkg::ADDR_X_HIGH};
      sel_low = {reg_addr == accel_offset_pkg::ADDR_Z_LOW,
                 reg_addr == accel_offset_pkg::ADDR_Y_LOW,
                 reg_addr == accel_offset_pkg::ADDR_X_LOW};
    end
  end

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb
  begin
    next_reg_rdata = 8'h00;
    next_reg_hit = 1'b0;
    for (int i = 0; i < accel_offset_pkg::AXES; i++)
    begin
      next_offset_high[i] = offset_high[i];
      next_offset_low[i] = offset_low[i];
      if (reg_write && sel_high[i])
        next_offset_high[i] = reg_wdata;
      if (reg_write && sel_low[i])
        next_offset_low[i] = reg_wdata & accel_offset_pkg::LOW_WRITE_MASK;
      if (reg_read && sel_high[i])
      begin
        next_reg_rdata = offset_high[i];
        next_reg_hit = 1'b1;
      end
      if (reg_read && sel_low[i])
      begin
        next_reg_rdata = offset_low[i];
        next_reg_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Offset correction per axis
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < accel_offset_pkg::AXES; g++)
    begin : g_axis
      logic signed [14:0] offset_value;
      logic signed [15:0] sample;
      assign offset_value = {offset_high[g], offset_low[g][7:1]};
      assign sample = raw_sample[g*16 +: 16];
      // Same 0.98 mg step in every range; sum wraps at 16 bits
      assign next_corrected_sample[g*16 +: 16] = 16'(sample + 16'(offset_value));
    end
  endgenerate

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < accel_offset_pkg::AXES; i++)
      begin
        offset_high[i] <= accel_offset_pkg::OFFSET_RESET;
        offset_low[i] <= accel_offset_pkg::OFFSET_RESET;
      end
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      corrected_sample <= 48'h0;
    end
    else
    begin
      for (int i = 0; i < accel_offset_pkg::AXES; i++)
      begin
        offset_high[i] <= next_offset_high[i];
        offset_low[i] <= next_offset_low[i];
      end
      reg_rdata <= next_reg_rdata;
      reg_hit <= next_reg_hit;
      corrected_sample <= next_corrected_sample;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  low_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    offset_low[0][0] == 1'b0 && offset_low[1][0] == 1'b0 && offset_low[2][0] == 1'b0)
    else $error("reserved low bit set");
  y_high_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_Y_HIGH
    |=> offset_high[1] == $past(reg_wdata))
    else $error("y high write lost");
  z_low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_Z_LOW
    |=> offset_low[2] == ($past(reg_wdata) & accel_offset_pkg::LOW_WRITE_MASK))
    else $error("z low write lost");
  x_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_read && !reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_X_HIGH
    |=> reg_hit && reg_rdata == offset_high[0])
    else $error("x high readback wrong");
  legacy_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && legacy_mode && reg_addr == accel_offset_pkg::LEGACY_Y_HIGH
    |=> offset_high[1] == $past(reg_wdata))
    else $error("legacy y high write lost");
  legacy_native_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_read && legacy_mode && reg_addr == accel_offset_pkg::ADDR_X_HIGH |=> !reg_hit)
    else $error("native address hit in legacy mode");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_read && !reg_hit && !legacy_mode && reg_addr == 8'h79 |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  correct_x_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $stable(offset_high[0]) && $stable(offset_low[0])
    |=> corrected_sample[15:0] == 16'($past(raw_sample[15:0])
    + $past({offset_high[0][7], offset_high[0], offset_low[0][7:1]})))
    else $error("x correction wrong");

  // ----------------------------------------
  // Write checks
  // ----------------------------------------
  x_high_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_X_HIGH
    |=> offset_high[0] == $past(reg_wdata))
    else $error("x high write lost");
  x_low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_X_LOW
    |=> offset_low[0] == ($past(reg_wdata) & accel_offset_pkg::LOW_WRITE_MASK))
    else $error("x low write lost");
  y_low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_Y_LOW
    |=> offset_low[1] == ($past(reg_wdata) & accel_offset_pkg::LOW_WRITE_MASK))
    else $error("y low write lost");
  z_high_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_Z_HIGH
    |=> offset_high[2] == $past(reg_wdata))
    else $error("z high write lost");
  legacy_x_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && legacy_mode && reg_addr == accel_offset_pkg::LEGACY_X_LOW
    |=> offset_low[0] == ($past(reg_wdata) & accel_offset_pkg::LOW_WRITE_MASK))
    else $error("legacy x low write lost");
  legacy_z_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_write && legacy_mode && reg_addr == accel_offset_pkg::LEGACY_Z_HIGH
    |=> offset_high[2] == $past(reg_wdata))
    else $error("legacy z high write lost");
  offsets_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_write |=> $stable(offset_high[0]) && $stable(offset_high[1])
    && $stable(offset_high[2]) && $stable(offset_low[0])
    && $stable(offset_low[1]) && $stable(offset_low[2]))
    else $error("offset changed without write");

  // ----------------------------------------
  // Read checks
  // ----------------------------------------
  idle_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_read |=> !reg_hit && reg_rdata == 8'h00)
    else $error("read answer without request");
  y_readback_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_read && !reg_write && !legacy_mode && reg_addr == accel_offset_pkg::ADDR_Y_LOW
    |=> reg_hit && reg_rdata == offset_low[1])
    else $error("y low readback wrong");
  legacy_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_read && !reg_write && legacy_mode && reg_addr == accel_offset_pkg::LEGACY_Z_LOW
    |=> reg_hit && reg_rdata == offset_low[2])
    else $error("legacy z low readback wrong");

  // ----------------------------------------
  // Sample path checks
  // ----------------------------------------
  correct_y_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> corrected_sample[31:16] == 16'($past(raw_sample[31:16])
    + $past({offset_high[1][7], offset_high[1], offset_low[1][7:1]})))
    else $error("y correction wrong");
  correct_z_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> corrected_sample[47:32] == 16'($past(raw_sample[47:32])
    + $past({offset_high[2][7], offset_high[2], offset_low[2][7:1]})))
    else $error("z correction wrong");

endmodule : accel_offset_registers

`default_nettype wire

// ### accel_offset_pkg.sv
// Constants for the accelerometer offset register bank
package accel_offset_pkg;

  // ----------------------------------------
  // Native addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_X_HIGH = 8'h77;
  localparam logic [7:0] ADDR_X_LOW = 8'h78;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h7a;
  localparam logic [7:0] ADDR_Y_LOW = 8'h7b;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h7d;
  localparam logic [7:0] ADDR_Z_LOW = 8'h7e;

  // ----------------------------------------
  // Legacy-compatible addresses
  // ----------------------------------------
  localparam logic [7:0] LEGACY_X_HIGH = 8'h06;
  localparam logic [7:0] LEGACY_X_LOW = 8'h07;
  localparam logic [7:0] LEGACY_Y_HIGH = 8'h08;
  localparam logic [7:0] LEGACY_Y_LOW = 8'h09;
  localparam logic [7:0] LEGACY_Z_HIGH = 8'h0a;
  localparam logic [7:0] LEGACY_Z_LOW = 8'h0b;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] LOW_WRITE_MASK = 8'hfe;
  localparam int OFFSET_WIDTH = 15;
  localparam int SAMPLE_WIDTH = 16;
  localparam int AXES = 3;

endpackage : accel_offset_pkg

// ### tb.sv
// Self-checking bench for the accelerometer offset register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic legacy_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic [47:0] raw_sample = 48'h0;
  logic [47:0] corrected_sample;
  logic [7:0] mdl [6] = '{default: 8'h00};
  logic [7:0] nat [6] = '{accel_offset_pkg::ADDR_X_HIGH, accel_offset_pkg::ADDR_X_LOW,
    accel_offset_pkg::ADDR_Y_HIGH, accel_offset_pkg::ADDR_Y_LOW,
    accel_offset_pkg::ADDR_Z_HIGH, accel_offset_pkg::ADDR_Z_LOW};
  int bad_count = 0;
  int checks_done = 0;

  accel_offset_registers i_dut (.core_clk(core_clk), .rst_n(rst_n), .legacy_mode(legacy_mode),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .raw_sample(raw_sample),
    .corrected_sample(corrected_sample));

  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic hit);
    @(negedge core_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge core_clk);
    reg_read = 1'b0;
    chk("reg_rdata", 48'(reg_rdata), 48'(d));
    chk("reg_hit", 48'(reg_hit), 48'(hit));
  endtask : rd

  function automatic logic [47:0] model_out(input logic [47:0] raw);
    logic [14:0] off;
    for (int k = 0; k < 3; k++)
    begin
      off = {mdl[2*k], mdl[2*k+1][7:1]};
      model_out[16*k +: 16] = raw[16*k +: 16] + {off[14], off};
    end
  endfunction : model_out

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d;
    void'($urandom(74610));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(nat[i], 8'h00, 1'b1);
    $display("test reset_values ended");
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      wr(nat[i], d);
      mdl[i] = (i % 2 == 1) ? (d & 8'hfe) : d;
    end
    wr(8'h79, 8'($urandom));
    for (int i = 0; i < 6; i++) rd(nat[i], mdl[i], 1'b1);
    rd(8'h79, 8'h00, 1'b0);
    rd(accel_offset_pkg::LEGACY_X_HIGH, 8'h00, 1'b0);
    $display("test native_map ended");
    legacy_mode = 1'b1;
    for (int i = 0; i < 6; i++) rd(8'h06 + 8'(i), mdl[i], 1'b1);
    rd(nat[0], 8'h00, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      wr(8'h06 + 8'(i), d);
      mdl[i] = (i % 2 == 1) ? (d & 8'hfe) : d;
    end
    wr(nat[1], 8'($urandom));
    legacy_mode = 1'b0;
    for (int i = 0; i < 6; i++) rd(nat[i], mdl[i], 1'b1);
    // Read and write in one cycle return the old value
    d = 8'($urandom);
    @(negedge core_clk);
    reg_addr = nat[2];
    reg_wdata = d;
    reg_write = 1'b1;
    reg_read = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    chk("reg_rdata", 48'(reg_rdata), 48'(mdl[2]));
    mdl[2] = d;
    rd(nat[2], mdl[2], 1'b1);
    $display("test legacy_map ended");
    for (int n = 0; n < 24; n++)
    begin
      raw_sample = 48'({$urandom, $urandom});
      @(negedge core_clk);
      chk("corrected_sample", corrected_sample, model_out(raw_sample));
    end
    $display("test sample_path ended");
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    chk("corrected_sample", corrected_sample, 48'h0);
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    mdl = '{default: 8'h00};
    for (int i = 0; i < 6; i++) rd(nat[i], mdl[i], 1'b1);
    raw_sample = 48'({$urandom, $urandom});
    @(negedge core_clk);
    chk("corrected_sample", corrected_sample, model_out(raw_sample));
    $display("test mid_reset ended");
    print_verdict();
  end

  // Watchdog against a hung run
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule : tb

`default_nettype wire
